/* File: wdt_cfg.svh */
// Register indices, field positions, reset values and timing counts of the watchdog block
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ---------------------------------------------------------------
// Register indices (byte address on APB is four times the index)
// ---------------------------------------------------------------
`define WDT_IDX_CLKCTRL     8'h8e
`define WDT_IDX_TAKEY       8'hc7
`define WDT_IDX_WDCTRL      8'hd8
`define WDT_IDX_EIE         8'he8
`define WDT_IDX_EIP         8'hf8

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define WDT_B_PWRON         6
`define WDT_B_SPARE5        5
`define WDT_B_SPARE4        4
`define WDT_B_TOFLAG        3
`define WDT_B_RSTFLAG       2
`define WDT_B_RSTEN         1
`define WDT_B_RESTART       0
`define WDT_B_IRQEN         4
`define WDT_B_IRQPRI        4
`define WDT_B_LENSEL_HI     7
`define WDT_B_LENSEL_LO     6

// ---------------------------------------------------------------
// Reset values and fixed read patterns
// ---------------------------------------------------------------
`define WDT_CLKCTRL_RST     8'h01
`define WDT_EIE_RST         5'h00
`define WDT_EIP_RST         5'h00
`define WDT_EIE_RSVD_ONES   3'h7
`define WDT_KEY_FIRST       8'haa
`define WDT_KEY_SECOND      8'h55

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define WDT_MCYC_CLKS       4
`define WDT_WIN_MCYC        3
`define WDT_WIN_CLKS        (`WDT_WIN_MCYC * `WDT_MCYC_CLKS)
`define WDT_GRACE_CLKS      512
`define WDT_CNT_W           26

`endif

/* File: wdt_pkg.sv */
// Types shared by the watchdog control block
package wdt_pkg;
  `include "wdt_cfg.svh"

  // Timed-access key sequence
  typedef enum logic [1:0] {
    WDT_KEY_IDLE = 2'b00,
    WDT_KEY_HALF = 2'b01,
    WDT_KEY_OPEN = 2'b10
  } wdt_key_e;

  typedef logic [7:0]            wdt_byte_t;
  typedef logic [`WDT_CNT_W-1:0] wdt_cnt_t;
endpackage

/* File: wdt_core_if.sv */
// Control and event signals between the register block and the watchdog counter core
`timescale 1ns/100ps
interface wdt_core_if;
  logic       restart;
  logic       run;
  logic       armed;
  logic [1:0] lenSel;
  logic       timeout;
  logic       fire;
  logic       graceAct;

  modport ctrl (output restart, output run, output armed, output lenSel,
                input timeout, input fire, input graceAct);
  modport core (input restart, input run, input armed, input lenSel,
                output timeout, output fire, output graceAct);
endinterface

/* File: wdt_core.sv */
// Watchdog counter with selectable length and the grace period before reset
`timescale 1ns/100ps
module wdt_core import wdt_pkg::*; #(
  parameter int unsigned LEN0_BITS = 17,
  parameter int unsigned LEN1_BITS = 20,
  parameter int unsigned LEN2_BITS = 23,
  parameter int unsigned LEN3_BITS = 26
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control and events
  wdt_core_if.core cif
);
  localparam logic [9:0] GRACE_LAST = 10'(`WDT_GRACE_CLKS - 1);

  wdt_cnt_t    cnt_r, cnt_nxt, limit;
  logic [9:0]  graceCnt_r, graceCnt_nxt;
  logic        graceAct_r, graceAct_nxt;
  logic        tout_r, tout_nxt;
  logic        fire_r, fire_nxt;
  int unsigned lenBits;

  // Terminal count for the selected length
  always_comb begin
    unique case (cif.lenSel)
      2'b00: lenBits = LEN0_BITS;
      2'b01: lenBits = LEN1_BITS;
      2'b10: lenBits = LEN2_BITS;
      2'b11: lenBits = LEN3_BITS;
    endcase
    limit = wdt_cnt_t'((64'd1 << lenBits) - 64'd1);
  end

  // Counting, time-out and grace period
  always_comb begin
    cnt_nxt      = cnt_r;
    graceCnt_nxt = graceCnt_r;
    graceAct_nxt = graceAct_r;
    tout_nxt     = 1'b0;
    fire_nxt     = 1'b0;
    if (cif.restart) begin
      cnt_nxt      = '0;
      graceCnt_nxt = '0;
      graceAct_nxt = 1'b0;
    end else if (cif.run) begin
      if (cnt_r == limit) begin
        cnt_nxt  = '0;
        tout_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + wdt_cnt_t'(1);
      end
      // Disarming mid-way drops the pending reset
      if (graceAct_r) begin
        if (!cif.armed) begin
          graceAct_nxt = 1'b0;
        end else if (graceCnt_r == GRACE_LAST) begin
          fire_nxt     = 1'b1;
          graceAct_nxt = 1'b0;
        end else begin
          graceCnt_nxt = graceCnt_r + 10'd1;
        end
      end
      if (tout_nxt && cif.armed && !graceAct_r) begin
        graceAct_nxt = 1'b1;
        graceCnt_nxt = '0;
      end
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r      <= '0;
      graceCnt_r <= '0;
      graceAct_r <= 1'b0;
      tout_r     <= 1'b0;
      fire_r     <= 1'b0;
    end else begin
      cnt_r      <= cnt_nxt;
      graceCnt_r <= graceCnt_nxt;
      graceAct_r <= graceAct_nxt;
      tout_r     <= tout_nxt;
      fire_r     <= fire_nxt;
    end
  end

  assign cif.timeout  = tout_r;
  assign cif.fire     = fire_r;
  assign cif.graceAct = graceAct_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_fire_after_grace;
    fire_r |-> $past(tout_r, 512);
  endproperty
  a_fire_after_grace: assert property (p_fire_after_grace) else $error("reset not 512 after timeout");

  property p_fire_needs_arm;
    fire_r |-> $past(cif.armed);
  endproperty
  a_fire_needs_arm: assert property (p_fire_needs_arm) else $error("reset fired while disarmed");

  property p_restart_zero;
    cif.restart |=> (cnt_r == '0) && !graceAct_r && !fire_r;
  endproperty
  a_restart_zero: assert property (p_restart_zero) else $error("counter not cleared by restart");

  // A frozen counter can never finish the grace period
  property p_powerdown_no_fire;
    !cif.run && !fire_r |=> !fire_r;
  endproperty
  a_powerdown_no_fire: assert property (p_powerdown_no_fire) else $error("reset in power-down");

  c_fire:    cover property (fire_r);
endmodule // wdt_core

/* File: wdt_watchdog_timer_control.sv */
// Watchdog control registers, timed-access protection and APB slave
`timescale 1ns/100ps
`include "wdt_cfg.svh"

module wdt_watchdog_timer_control import wdt_pkg::*; #(
  parameter int unsigned LEN0_BITS = 17,
  parameter int unsigned LEN1_BITS = 20,
  parameter int unsigned LEN2_BITS = 23,
  parameter int unsigned LEN3_BITS = 26
) (
  // Clock and power-on reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip pins
  input  wire logic        extRstPin,
  input  wire logic        powerDownPin,
  // Watchdog outputs
  output logic             wdogIrqReq,
  output logic             wdogIrqPriority,
  output logic             wdogSysReset
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pinMeta_r;
  logic [1:0] pinSync_r;
  logic       extRstS;
  logic       powerDownS;

  // Two flops per pin; only the second stage is read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinMeta_r <= 2'b00;
      pinSync_r <= 2'b00;
    end else begin
      pinMeta_r <= {extRstPin, powerDownPin};
      pinSync_r <= pinMeta_r;
    end
  end

  assign extRstS    = pinSync_r[1];
  assign powerDownS = pinSync_r[0];

  // ---------------------------------------------------------------
  // Counter core
  // ---------------------------------------------------------------
  wdt_core_if coreIf ();

  wdt_core #(
    .LEN0_BITS (LEN0_BITS),
    .LEN1_BITS (LEN1_BITS),
    .LEN2_BITS (LEN2_BITS),
    .LEN3_BITS (LEN3_BITS)
  ) u_core (
    .clk   (clk),
    .rst_b (rst_b),
    .cif   (coreIf.core)
  );

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [7:0] regIdx;
  logic       setupPh;
  logic       accWr;
  logic       mapped;
  logic       wrClk;
  logic       wrKey;
  logic       wrCtl;
  logic       wrEie;
  logic       wrEip;
  wdt_byte_t  wrByte;

  assign regIdx  = paddr[9:2];
  assign setupPh = psel & ~penable;
  assign wrByte  = pwdata[7:0];

  // Index decode; top address bits must be zero
  always_comb begin
    mapped = 1'b0;
    if (paddr[11:10] == 2'b00) begin
      unique case (regIdx)
        `WDT_IDX_CLKCTRL,
        `WDT_IDX_TAKEY,
        `WDT_IDX_WDCTRL,
        `WDT_IDX_EIE,
        `WDT_IDX_EIP: mapped = 1'b1;
        default:      mapped = 1'b0;
      endcase
    end
  end

  // Writes land only at the completing access edge
  logic pready_r;
  logic sysRst;

  assign accWr = psel & penable & pready_r & pwrite & mapped & ~sysRst;
  assign wrClk = accWr & (regIdx == `WDT_IDX_CLKCTRL);
  assign wrKey = accWr & (regIdx == `WDT_IDX_TAKEY);
  assign wrCtl = accWr & (regIdx == `WDT_IDX_WDCTRL);
  assign wrEie = accWr & (regIdx == `WDT_IDX_EIE);
  assign wrEip = accWr & (regIdx == `WDT_IDX_EIP);

  // External pin and watchdog fire both act as a chip reset
  assign sysRst = extRstS | coreIf.fire;

  // ---------------------------------------------------------------
  // Timed-access key sequence
  // ---------------------------------------------------------------
  wdt_key_e   keyState_r, keyState_nxt;
  logic [3:0] winCnt_r, winCnt_nxt;
  logic       winOpen;

  assign winOpen = (keyState_r == WDT_KEY_OPEN);

  // Any write to a mapped register between the two keys, other than a repeated first key, breaks the sequence
  always_comb begin
    keyState_nxt = keyState_r;
    winCnt_nxt   = winCnt_r;
    if (sysRst) begin
      keyState_nxt = WDT_KEY_IDLE;
      winCnt_nxt   = 4'd0;
    end else begin
      if (keyState_r == WDT_KEY_OPEN) begin
        if (winCnt_r == 4'd1) begin
          keyState_nxt = WDT_KEY_IDLE;
        end
        winCnt_nxt = winCnt_r - 4'd1;
      end
      if (wrKey && (wrByte == `WDT_KEY_FIRST)) begin
        keyState_nxt = WDT_KEY_HALF;
        winCnt_nxt   = 4'd0;
      end else if (wrKey && (keyState_r == WDT_KEY_HALF) &&
                   (wrByte == `WDT_KEY_SECOND)) begin
        keyState_nxt = WDT_KEY_OPEN;
        winCnt_nxt   = 4'(`WDT_WIN_CLKS);
      end else if (accWr && (keyState_r == WDT_KEY_HALF)) begin
        keyState_nxt = WDT_KEY_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keyState_r <= WDT_KEY_IDLE;
      winCnt_r   <= 4'd0;
    end else begin
      keyState_r <= keyState_nxt;
      winCnt_r   <= winCnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog control register
  // ---------------------------------------------------------------
  logic porFlag_r, porFlag_nxt;
  logic spare5_r, spare5_nxt;
  logic spare4_r, spare4_nxt;
  logic toFlag_r, toFlag_nxt;
  logic rstFlag_r, rstFlag_nxt;
  logic rstEn_r, rstEn_nxt;
  logic restart_r, restart_nxt;

  // Hardware sets are applied after software writes so they win
  always_comb begin
    porFlag_nxt = porFlag_r;
    spare5_nxt  = spare5_r;
    spare4_nxt  = spare4_r;
    toFlag_nxt  = toFlag_r;
    rstFlag_nxt = rstFlag_r;
    rstEn_nxt   = rstEn_r;
    restart_nxt = 1'b0;
    if (sysRst) begin
      spare5_nxt = 1'b0;
      toFlag_nxt = 1'b0;
      if (coreIf.fire) begin
        rstFlag_nxt = 1'b1;
      end
    end else begin
      if (wrCtl) begin
        spare5_nxt  = wrByte[`WDT_B_SPARE5];
        spare4_nxt  = wrByte[`WDT_B_SPARE4];
        rstFlag_nxt = wrByte[`WDT_B_RSTFLAG];
        if (winOpen) begin
          porFlag_nxt = wrByte[`WDT_B_PWRON];
          toFlag_nxt  = wrByte[`WDT_B_TOFLAG];
          rstEn_nxt   = wrByte[`WDT_B_RSTEN];
          restart_nxt = wrByte[`WDT_B_RESTART];
        end
      end
      if (coreIf.timeout) begin
        toFlag_nxt = 1'b1;
      end
    end
  end

  // Power-on values; other resets go through the next-value logic
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      porFlag_r <= 1'b1;
      spare5_r  <= 1'b0;
      spare4_r  <= 1'b0;
      toFlag_r  <= 1'b0;
      rstFlag_r <= 1'b0;
      rstEn_r   <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      porFlag_r <= porFlag_nxt;
      spare5_r  <= spare5_nxt;
      spare4_r  <= spare4_nxt;
      toFlag_r  <= toFlag_nxt;
      rstFlag_r <= rstFlag_nxt;
      rstEn_r   <= rstEn_nxt;
      restart_r <= restart_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt enable, priority and clock control
  // ---------------------------------------------------------------
  logic [4:0] eie_r, eie_nxt;
  logic [4:0] eip_r, eip_nxt;
  wdt_byte_t  clkCtl_r, clkCtl_nxt;

  // Freely writable; only the low five bits of the interrupt registers exist
  always_comb begin
    eie_nxt    = eie_r;
    eip_nxt    = eip_r;
    clkCtl_nxt = clkCtl_r;
    if (sysRst) begin
      eie_nxt    = `WDT_EIE_RST;
      eip_nxt    = `WDT_EIP_RST;
      clkCtl_nxt = `WDT_CLKCTRL_RST;
    end else begin
      if (wrEie) begin
        eie_nxt = wrByte[4:0];
      end
      if (wrEip) begin
        eip_nxt = wrByte[4:0];
      end
      if (wrClk) begin
        clkCtl_nxt = wrByte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eie_r    <= `WDT_EIE_RST;
      eip_r    <= `WDT_EIP_RST;
      clkCtl_r <= `WDT_CLKCTRL_RST;
    end else begin
      eie_r    <= eie_nxt;
      eip_r    <= eip_nxt;
      clkCtl_r <= clkCtl_nxt;
    end
  end

  // Core control; power-down freezes counting so no reset can fire
  assign coreIf.restart = restart_r | sysRst;
  assign coreIf.run     = ~powerDownS;
  assign coreIf.armed   = rstEn_r;
  assign coreIf.lenSel  = clkCtl_r[`WDT_B_LENSEL_HI:`WDT_B_LENSEL_LO];

  // ---------------------------------------------------------------
  // APB answer and outputs
  // ---------------------------------------------------------------
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        irqReq_r, prio_r, sysRstOut_r;
  wdt_byte_t   rdByte;

  // Read mux; reserved bits of the enable register read as ones
  always_comb begin
    unique case (regIdx)
      `WDT_IDX_CLKCTRL: rdByte = clkCtl_r;
      `WDT_IDX_WDCTRL:  rdByte = {1'b0, porFlag_r, spare5_r, spare4_r,
                                  toFlag_r, rstFlag_r, rstEn_r, restart_r};
      `WDT_IDX_EIE:     rdByte = {`WDT_EIE_RSVD_ONES, eie_r};
      `WDT_IDX_EIP:     rdByte = {3'b000, eip_r};
      default:          rdByte = 8'h00;
    endcase
  end

  // Zero-wait slave: answer in the first access cycle
  always_comb begin
    pready_nxt  = setupPh & ~pready_r;
    pslverr_nxt = setupPh & ~mapped;
    prdata_nxt  = prdata_r;
    if (setupPh) begin
      prdata_nxt = mapped ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata_r    <= 32'h00000000;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
      irqReq_r    <= 1'b0;
      prio_r      <= 1'b0;
      sysRstOut_r <= 1'b0;
    end else begin
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      irqReq_r    <= toFlag_r & eie_r[`WDT_B_IRQEN];
      prio_r      <= eip_r[`WDT_B_IRQPRI];
      sysRstOut_r <= coreIf.fire;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign wdogIrqReq      = irqReq_r;
  assign wdogIrqPriority = prio_r;
  assign wdogSysReset    = sysRstOut_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_por_clear_by_write;
    $fell(porFlag_r) |-> $past(wrCtl && winOpen);
  endproperty
  a_por_clear_by_write: assert property (p_por_clear_by_write) else $error("power flag lost");

  property p_timeout_flag;
    coreIf.timeout && !sysRst |=> toFlag_r ##1 (irqReq_r == $past(eie_r[`WDT_B_IRQEN]));
  endproperty
  a_timeout_flag: assert property (p_timeout_flag) else $error("time-out flag not set");

  property p_fire_sets_flag;
    coreIf.fire |=> rstFlag_r && wdogSysReset;
  endproperty
  a_fire_sets_flag: assert property (p_fire_sets_flag) else $error("reset flag not set");

  property p_ext_keeps_flag;
    extRstS && !coreIf.fire |=> $stable(rstFlag_r) && $stable(rstEn_r) && $stable(porFlag_r);
  endproperty
  a_ext_keeps_flag: assert property (p_ext_keeps_flag) else $error("external reset altered bits");

  property p_ext_pattern;
    extRstS |=> !toFlag_r && !spare5_r && !restart_r;
  endproperty
  a_ext_pattern: assert property (p_ext_pattern) else $error("external reset pattern wrong");

  property p_restart_selfclear;
    restart_r |=> !restart_r;
  endproperty
  a_restart_selfclear: assert property (p_restart_selfclear) else $error("restart stuck");

  property p_protected_needs_window;
    $rose(rstEn_r) || $fell(rstEn_r) |-> $past(winOpen);
  endproperty
  a_protected_needs_window: assert property (p_protected_needs_window) else $error("unkeyed write");

  // A reset or a new key may cut the window short, so only the load and the count are checked
  property p_window_length;
    $rose(winOpen) |-> (winCnt_r == 4'(`WDT_WIN_CLKS));
  endproperty
  a_window_length: assert property (p_window_length) else $error("window length wrong");

  property p_window_close;
    winOpen && !sysRst && !wrKey |=> (winOpen != ($past(winCnt_r) == 4'd1));
  endproperty
  a_window_close: assert property (p_window_close) else $error("window closed wrongly");

  property p_eie_reserved;
    pready_r && !pwrite && $past(regIdx) == `WDT_IDX_EIE |-> prdata[7:5] == 3'b111;
  endproperty
  a_eie_reserved: assert property (p_eie_reserved) else $error("reserved bits not high");

  c_window_open: cover property ($rose(winOpen));
  c_wdog_reset:  cover property (wdogSysReset);
  c_irq:         cover property ($rose(wdogIrqReq));
  c_unmapped:    cover property (pready_r && pslverr_r);
endmodule // wdt_watchdog_timer_control

/* File: wdt_testbench.sv */
// Self-checking testbench of the watchdog control block
`timescale 1ns/100ps
`include "wdt_cfg.svh"

module testbench import wdt_pkg::*;;
  // Clock, reset and pins
  logic        clk;
  logic        rst_b;
  logic        extRstPin;
  logic        powerDownPin;
  // APB master side
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  // Watchdog outputs
  logic        wdogIrqReq;
  logic        wdogIrqPriority;
  logic        wdogSysReset;
  // Bookkeeping
  int          mismatches = 0;
  int          comparisons = 0;
  int          rstCnt = 0;
  int          n;

  // Short periods keep the time-out at 16 clocks at the reset length setting, and at most 128 clocks
  wdt_watchdog_timer_control #(.LEN0_BITS(4), .LEN1_BITS(5), .LEN2_BITS(6), .LEN3_BITS(7)) dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extRstPin(extRstPin), .powerDownPin(powerDownPin), .wdogIrqReq(wdogIrqReq),
    .wdogIrqPriority(wdogIrqPriority), .wdogSysReset(wdogSysReset));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Count watchdog reset pulses, to catch one fired while disarmed
  always @(posedge clk) begin
    if (wdogSysReset === 1'b1) rstCnt <= rstCnt + 1;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; pready and data are taken at the rising edge that completes it
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd  = prdata;
    err = pslverr;
    if (k >= 50) mismatches++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Masked read compare; bit 3 is masked where a time-out may land
  task automatic rdc(input logic [7:0] idx, input logic [7:0] msk, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd & {24'h000000, msk}, {24'h000000, exp});
  endtask

  task automatic key;
    apb(1'b1, `WDT_IDX_TAKEY, `WDT_KEY_FIRST);
    apb(1'b1, `WDT_IDX_TAKEY, `WDT_KEY_SECOND);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rdc(`WDT_IDX_WDCTRL, 8'hf7, 8'h40);
    rdc(`WDT_IDX_EIE, 8'hff, 8'he0);
    rdc(`WDT_IDX_EIP, 8'hff, 8'h00);
    rdc(`WDT_IDX_CLKCTRL, 8'hff, 8'h01);
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `WDT_IDX_EIP, 8'h10);
    repeat (2) @(negedge clk);
    chk({31'h0, wdogIrqPriority}, 32'h1);
  endtask

  // Protected bits hold without the key, free bits always write
  task automatic t_protect;
    apb(1'b1, `WDT_IDX_WDCTRL, 8'h30);
    rdc(`WDT_IDX_WDCTRL, 8'hf7, 8'h70);
    key();
    apb(1'b1, `WDT_IDX_WDCTRL, 8'h00);
    rdc(`WDT_IDX_WDCTRL, 8'hf7, 8'h00);
  endtask

  task automatic t_restart;
    key();
    apb(1'b1, `WDT_IDX_WDCTRL, 8'h01);
    rdc(`WDT_IDX_WDCTRL, 8'hff, 8'h00);
    repeat (6) @(posedge clk);
    rdc(`WDT_IDX_WDCTRL, 8'hff, 8'h00);
    repeat (700) @(posedge clk);
    rdc(`WDT_IDX_WDCTRL, 8'hff, 8'h08);
    chk(rstCnt, 0);
  endtask

  // Armed time-out: interrupt, then reset 512 clocks after the time-out
  task automatic t_wdreset;
    apb(1'b1, `WDT_IDX_EIE, 8'h10);
    rdc(`WDT_IDX_EIE, 8'hff, 8'hf0);
    key();
    apb(1'b1, `WDT_IDX_WDCTRL, 8'h02);
    n = 0;
    while (wdogIrqReq !== 1'b0 && n < 20) begin @(negedge clk); n++; end
    chk({31'h0, wdogIrqReq}, 32'h0);
    n = 0;
    while (wdogIrqReq !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    chk({31'h0, wdogIrqReq}, 32'h1);
    n = 0;
    while (wdogSysReset !== 1'b1 && n < 1000) begin @(negedge clk); n++; end
    chk(n, 511);
    @(negedge clk);
    chk({31'h0, wdogSysReset}, 32'h0);
    repeat (4) @(posedge clk);
    rdc(`WDT_IDX_WDCTRL, 8'hf7, 8'h06);
    rdc(`WDT_IDX_EIE, 8'hff, 8'he0);
    key();
    apb(1'b1, `WDT_IDX_WDCTRL, 8'h00);
  endtask

  task automatic t_ext;
    apb(1'b1, `WDT_IDX_CLKCTRL, 8'hc0);
    rdc(`WDT_IDX_CLKCTRL, 8'hff, 8'hc0);
    key();
    apb(1'b1, `WDT_IDX_WDCTRL, 8'h75);
    rdc(`WDT_IDX_WDCTRL, 8'hf7, 8'h74);
    @(posedge clk) extRstPin <= 1'b1;
    repeat (6) @(posedge clk);
    extRstPin <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(`WDT_IDX_WDCTRL, 8'hf7, 8'h54);
    rdc(`WDT_IDX_CLKCTRL, 8'hff, 8'h01);
  endtask

  // Armed enable and reset flag are dropped by power-on; power-down freezes the count
  task automatic t_por;
    key();
    apb(1'b1, `WDT_IDX_WDCTRL, 8'h56);
    @(posedge clk) rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rdc(`WDT_IDX_WDCTRL, 8'hf7, 8'h40);
    powerDownPin <= 1'b1;
    repeat (60) @(posedge clk);
    rdc(`WDT_IDX_WDCTRL, 8'hff, 8'h40);
    powerDownPin <= 1'b0;
    repeat (30) @(posedge clk);
    rdc(`WDT_IDX_WDCTRL, 8'hff, 8'h48);
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    extRstPin = 1'b0;
    powerDownPin = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_protect();
    t_restart();
    t_wdreset();
    t_ext();
    t_por();
    end_sim();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule // testbench
